// ### adc_control_registers.sv
// control and status registers, conversion sequencer and input routing of the 12-bit converter
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "adc_ctrl_map.svh"

module adc_control_registers #(
    parameter int RESULT_BITS = 12,
    parameter int PIN_COUNT = 4
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [7:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [7:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    input wire logic [11:0] conv_result_in,
    output logic converter_power_out,
    output logic conv_clock_tick_out,
    output logic sample_phase_out,
    output logic convert_phase_out,
    output logic conv_busy_flag_out,
    output logic conv_done_flag_out,
    output logic [3:0] analog_pin_route_out,
    output logic bandgap_route_out,
    output logic ground_route_out,
    output logic reference_internal_out,
    output logic reference_pin_route_out,
    input wire logic [3:0] pin_pull_high_in,
    output logic [3:0] pin_pull_high_out,
    input wire logic [3:0] pin_dir_oe_in,
    output logic [3:0] pin_oe_out,
    output logic [3:0] pin_alt_enable_out
);

    generate
        if (RESULT_BITS != 12 || PIN_COUNT != 4) begin : bad_params
            $error("result width must be 12 and pin count 4");
        end
    endgenerate

    adc_ctrl_pkg::regs_type state_r;
    adc_ctrl_pkg::regs_type state_nxt;

    logic div_tick;
    logic running;
    logic src_external;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;

    // true when the source code selects an external pin
    function automatic logic is_external(input logic [2:0] code);
        is_external = (code == `SRC_EXTERNAL) || (code > `SRC_GND_LAST);
    endfunction

    // true when the source code ties the input to ground
    function automatic logic is_ground(input logic [2:0] code);
        is_ground = (code >= `SRC_GND_FIRST) && (code <= `SRC_GND_LAST);
    endfunction

    // last count of the divider for a given divide code
    function automatic logic [6:0] div_last(input logic [2:0] code);
        logic [7:0] full;
        full = (8'h01 << code) - 8'h01;
        div_last = full[6:0];
    endfunction

    // high result byte in the chosen format
    function automatic logic [7:0] fmt_high(input logic fmt, input logic [11:0] d);
        if (fmt) begin
            fmt_high = {4'h0, d[11:8]};
        end else begin
            fmt_high = d[11:4];
        end
    endfunction

    // low result byte in the chosen format
    function automatic logic [7:0] fmt_low(input logic fmt, input logic [11:0] d);
        if (fmt) begin
            fmt_low = d[7:0];
        end else begin
            fmt_low = {d[3:0], 4'h0};
        end
    endfunction

    assign running = (state_r.state != adc_ctrl_pkg::conv_idle);
    assign div_tick = running && (state_r.div_cnt == div_last(state_r.div));
    assign src_external = is_external(state_r.src);
    assign wr_byte = state_r.w_data[7:0];

    // read multiplexer for the byte register picked by araddr
    always_comb begin
        rd_byte = `RESET_BYTE;
        unique case ({araddr_in[7:2], 2'h0})
            `OFS_CONTROL_STATUS: begin
                rd_byte[`CTRL_START_BIT] = state_r.start;
                rd_byte[`CTRL_BUSY_BIT] = state_r.busy;
                rd_byte[`CTRL_ENABLE_BIT] = state_r.enable;
                rd_byte[`CTRL_FORMAT_BIT] = state_r.fmt;
                rd_byte[`CTRL_CHAN_LSB +: 2] = state_r.chan;
            end
            `OFS_SOURCE_CLOCK: begin
                rd_byte[`SRC_SOURCE_LSB +: 3] = state_r.src;
                rd_byte[`SRC_VREF_LSB +: 2] = state_r.vref;
                rd_byte[`SRC_DIV_LSB +: 3] = state_r.div;
            end
            `OFS_RESULT_HIGH: begin
                rd_byte = state_r.res_hi;
            end
            `OFS_RESULT_LOW: begin
                rd_byte = state_r.res_lo;
            end
            `OFS_PIN_SHARE: begin
                rd_byte[`SHARE_VREF_BIT:0] = state_r.share;
            end
            `OFS_DONE_FLAG: begin
                rd_byte[`DONE_FLAG_BIT] = state_r.done_flag;
            end
            default: begin
                rd_byte = `RESET_BYTE;
            end
        endcase
    end

    always_comb begin
        logic wr_fire;
        logic launch;
        logic finish;
        logic new_start;
        logic new_enable;
        wr_fire = 1'b0;
        launch = 1'b0;
        finish = 1'b0;
        new_start = state_r.start;
        new_enable = state_r.enable;
        state_nxt = state_r;

        // write address and data may arrive in either order
        if (awvalid_in && awready_out) begin
            state_nxt.aw_got = 1'b1;
            state_nxt.aw_addr = {awaddr_in[7:2], 2'h0};
        end
        if (wvalid_in && wready_out) begin
            state_nxt.w_got = 1'b1;
            state_nxt.w_data = wdata_in;
            state_nxt.w_strb = wstrb_in;
        end
        if (state_r.bvalid && bready_in) begin
            state_nxt.bvalid = 1'b0;
        end

        // conversion sequencer
        if (running) begin
            if (div_tick) begin
                state_nxt.div_cnt = 7'h00;
                if (state_r.period == `LAST_PERIOD) begin
                    finish = 1'b1;
                end else begin
                    state_nxt.period = state_r.period + 4'h1;
                    if (state_nxt.period >= `SAMPLE_PERIODS) begin
                        state_nxt.state = adc_ctrl_pkg::conv_convert;
                    end
                end
            end else begin
                state_nxt.div_cnt = state_r.div_cnt + 7'h01;
            end
        end

        if (finish) begin
            state_nxt.state = adc_ctrl_pkg::conv_idle;
            state_nxt.busy = 1'b0;
            state_nxt.done_flag = 1'b1;
            state_nxt.res_hi = fmt_high(state_r.fmt, conv_result_in);
            state_nxt.res_lo = fmt_low(state_r.fmt, conv_result_in);
        end

        // register write once both halves are held
        if (state_r.aw_got && state_r.w_got && !state_r.bvalid) begin
            wr_fire = 1'b1;
            state_nxt.aw_got = 1'b0;
            state_nxt.w_got = 1'b0;
            state_nxt.bvalid = 1'b1;
            state_nxt.bresp = `RESP_OKAY;
        end

        if (wr_fire) begin
            unique case (state_r.aw_addr)
                `OFS_CONTROL_STATUS: begin
                    if (state_r.w_strb[0]) begin
                        new_start = wr_byte[`CTRL_START_BIT];
                        new_enable = wr_byte[`CTRL_ENABLE_BIT];
                        state_nxt.start = new_start;
                        state_nxt.enable = new_enable;
                        state_nxt.fmt = wr_byte[`CTRL_FORMAT_BIT];
                        state_nxt.chan = wr_byte[`CTRL_CHAN_LSB +: 2];
                        // the busy bit of the written byte is dropped
                        launch = state_r.start && !new_start && new_enable && !running;
                    end
                end
                `OFS_SOURCE_CLOCK: begin
                    if (state_r.w_strb[0]) begin
                        state_nxt.src = wr_byte[`SRC_SOURCE_LSB +: 3];
                        state_nxt.vref = wr_byte[`SRC_VREF_LSB +: 2];
                        state_nxt.div = wr_byte[`SRC_DIV_LSB +: 3];
                    end
                end
                `OFS_PIN_SHARE: begin
                    if (state_r.w_strb[0]) begin
                        state_nxt.share = wr_byte[`SHARE_VREF_BIT:0];
                    end
                end
                `OFS_DONE_FLAG: begin
                    // write one clears; a completion in the same cycle wins
                    if (state_r.w_strb[0] && wr_byte[`DONE_FLAG_BIT] && !finish) begin
                        state_nxt.done_flag = 1'b0;
                    end
                end
                `OFS_RESULT_HIGH, `OFS_RESULT_LOW: begin
                    state_nxt.bresp = `RESP_OKAY;
                end
                default: begin
                    state_nxt.bresp = `RESP_SLVERR;
                end
            endcase
        end

        if (launch) begin
            state_nxt.state = adc_ctrl_pkg::conv_sample;
            state_nxt.busy = 1'b1;
            state_nxt.div_cnt = 7'h00;
            state_nxt.period = 4'h0;
        end

        // switching the converter off abandons a conversion, results stay
        if (!new_enable) begin
            state_nxt.state = adc_ctrl_pkg::conv_idle;
            state_nxt.busy = 1'b0;
            state_nxt.res_hi = state_r.res_hi;
            state_nxt.res_lo = state_r.res_lo;
            state_nxt.done_flag = state_nxt.done_flag && !(finish && !state_r.enable);
        end

        // read channel
        if (state_r.rvalid && rready_in) begin
            state_nxt.rvalid = 1'b0;
        end
        if (arvalid_in && arready_out) begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rdata = {24'h000000, rd_byte};
            unique case ({araddr_in[7:2], 2'h0})
                `OFS_CONTROL_STATUS, `OFS_SOURCE_CLOCK, `OFS_RESULT_HIGH,
                `OFS_RESULT_LOW, `OFS_PIN_SHARE, `OFS_DONE_FLAG: begin
                    state_nxt.rresp = `RESP_OKAY;
                end
                default: begin
                    state_nxt.rresp = `RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign awready_out = !state_r.aw_got && !state_r.bvalid;
    assign wready_out = !state_r.w_got && !state_r.bvalid;
    assign bvalid_out = state_r.bvalid;
    assign bresp_out = state_r.bresp;
    assign arready_out = !state_r.rvalid;
    assign rvalid_out = state_r.rvalid;
    assign rdata_out = state_r.rdata;
    assign rresp_out = state_r.rresp;

    assign converter_power_out = state_r.enable;
    assign conv_clock_tick_out = div_tick;
    assign sample_phase_out = (state_r.state == adc_ctrl_pkg::conv_sample);
    assign convert_phase_out = (state_r.state == adc_ctrl_pkg::conv_convert);
    assign conv_busy_flag_out = state_r.busy;
    assign conv_done_flag_out = state_r.done_flag;

    assign bandgap_route_out = state_r.enable && (state_r.src == `SRC_BANDGAP);
    assign ground_route_out = state_r.enable && is_ground(state_r.src);
    assign reference_internal_out = (state_r.vref == `VREF_INTERNAL);
    // the reference pin is joined only while the external reference is chosen and the pin is shared
    assign reference_pin_route_out = !reference_internal_out && state_r.share[`SHARE_VREF_BIT];

    // per pin routing and pin-share overrides
    generate
        for (genvar i = 0; i < PIN_COUNT; i++) begin : pin_gen
            // bandgap never meets a pin because routing needs an external source
            assign analog_pin_route_out[i] = state_r.enable && src_external && state_r.share[i] &&
                                             (state_r.chan == 2'(i));
            assign pin_pull_high_out[i] = pin_pull_high_in[i] && !state_r.share[i];
            assign pin_alt_enable_out[i] = !state_r.share[i];
            assign pin_oe_out[i] = pin_dir_oe_in[i] && !state_r.share[i];
        end
    endgenerate

endmodule

// ### adc_ctrl_map.svh
// register offsets, bit positions, reset values and counts of the converter control block
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define OFS_CONTROL_STATUS 8'h00
`define OFS_SOURCE_CLOCK 8'h04
`define OFS_RESULT_HIGH 8'h08
`define OFS_RESULT_LOW 8'h0C
`define OFS_PIN_SHARE 8'h10
`define OFS_DONE_FLAG 8'h14
`define CTRL_START_BIT 7
`define CTRL_BUSY_BIT 6
`define CTRL_ENABLE_BIT 5
`define CTRL_FORMAT_BIT 4
`define CTRL_CHAN_LSB 0
`define SRC_SOURCE_LSB 5
`define SRC_VREF_LSB 3
`define SRC_DIV_LSB 0
`define SHARE_VREF_BIT 4
`define DONE_FLAG_BIT 0
`define RESET_BYTE 8'h00
`define SRC_EXTERNAL 3'h0
`define SRC_BANDGAP 3'h1
`define SRC_GND_FIRST 3'h2
`define SRC_GND_LAST 3'h4
`define VREF_INTERNAL 2'h1
`define SAMPLE_PERIODS 4'h4
`define LAST_PERIOD 4'hF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### adc_ctrl_pkg.sv
// types of the converter control block
package adc_ctrl_pkg;

typedef enum logic [1:0] {
    conv_idle,
    conv_sample,
    conv_convert
} conv_state_type;

typedef struct packed {
    conv_state_type state;
    logic start;
    logic busy;
    logic enable;
    logic fmt;
    logic [1:0] chan;
    logic [2:0] src;
    logic [1:0] vref;
    logic [2:0] div;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [4:0] share;
    logic done_flag;
    logic [6:0] div_cnt;
    logic [3:0] period;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
} regs_type;

endpackage

// ### adc_control_registers_chk.sv
// assertion checker for the converter control block
`timescale 1ns/10ps
module adc_control_registers_chk (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic conv_busy_flag_out,
    input wire logic conv_done_flag_out,
    input wire logic converter_power_out,
    input wire logic sample_phase_out,
    input wire logic convert_phase_out,
    input wire logic [3:0] analog_pin_route_out,
    input wire logic bandgap_route_out,
    input wire logic ground_route_out,
    input wire logic reference_internal_out,
    input wire logic reference_pin_route_out,
    input wire logic [3:0] pin_pull_high_in,
    input wire logic [3:0] pin_pull_high_out,
    input wire logic [3:0] pin_dir_oe_in,
    input wire logic [3:0] pin_oe_out,
    input wire logic [3:0] pin_alt_enable_out
);
    logic [15:0] s_cnt;
    logic [15:0] c_cnt;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    // cycles spent in each phase of the running conversion
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            s_cnt <= 16'h0000;
            c_cnt <= 16'h0000;
        end else if (!sample_phase_out && !convert_phase_out) begin
            s_cnt <= 16'h0000;
            c_cnt <= 16'h0000;
        end else begin
            s_cnt <= s_cnt + 16'(sample_phase_out);
            c_cnt <= c_cnt + 16'(convert_phase_out);
        end
    end
    property p_busy_phase;
        sample_phase_out || convert_phase_out |-> conv_busy_flag_out && !(sample_phase_out && convert_phase_out);
    endproperty
    a_busy_phase: assert property (p_busy_phase) else $error("phase active without busy");
    property p_busy_start;
        $rose(conv_busy_flag_out) |-> sample_phase_out;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("launch without sampling");
    property p_done;
        $fell(conv_busy_flag_out) && converter_power_out |-> conv_done_flag_out;
    endproperty
    a_done: assert property (p_done) else $error("completion without done flag");
    property p_len;
        $fell(convert_phase_out) && converter_power_out |-> s_cnt != 16'h0000 && c_cnt == 3 * s_cnt;
    endproperty
    a_len: assert property (p_len) else $error("phase lengths not four to twelve");
    property p_pin_one;
        $onehot0(analog_pin_route_out);
    endproperty
    a_pin_one: assert property (p_pin_one) else $error("two pins routed");
    property p_bg;
        bandgap_route_out |-> !ground_route_out && analog_pin_route_out == 4'h0;
    endproperty
    a_bg: assert property (p_bg) else $error("bandgap joined to other input");
    property p_ref;
        reference_internal_out |-> !reference_pin_route_out;
    endproperty
    a_ref: assert property (p_ref) else $error("reference pin joined to supply");
    property p_off;
        !converter_power_out |-> !conv_busy_flag_out && !bandgap_route_out && analog_pin_route_out == 4'h0;
    endproperty
    a_off: assert property (p_off) else $error("activity while powered off");
    property p_pull;
        pin_pull_high_out == (pin_pull_high_in & pin_alt_enable_out);
    endproperty
    a_pull: assert property (p_pull) else $error("pull-high kept on analog pin");
    property p_oe;
        pin_oe_out == (pin_dir_oe_in & pin_alt_enable_out);
    endproperty
    a_oe: assert property (p_oe) else $error("direction not overridden");
    c_conv: cover property ($fell(convert_phase_out) && converter_power_out);
    c_bg: cover property (bandgap_route_out);
    c_abort: cover property ($fell(conv_busy_flag_out) && !converter_power_out);
endmodule
bind adc_control_registers adc_control_registers_chk adc_control_registers_chk_i (.*);

// ### adc_core_model.sv
// behavioural model of the analog converter core and input multiplexer
`timescale 1ns/10ps
module adc_core_model #(
    parameter logic [11:0] BANDGAP_CODE = 12'h7C3
) (
    input wire logic clk_in,
    input wire logic convert_phase_in,
    input wire logic [3:0] analog_pin_route_in,
    input wire logic bandgap_route_in,
    input wire logic ground_route_in,
    output logic [11:0] result_out
);
    logic [11:0] junk = 12'h000;
    // result is only meaningful while converting; otherwise it changes every cycle
    always_ff @(posedge clk_in) begin
        junk <= junk + 12'h3B7;
    end
    always_comb begin
        if (!convert_phase_in) begin
            result_out = junk;
        end else if (bandgap_route_in) begin
            result_out = BANDGAP_CODE;
        end else if (ground_route_in) begin
            result_out = 12'h000;
        end else begin
            result_out = {4'hA, analog_pin_route_in, 4'h5};
        end
    end
endmodule

// ### tb_adc_control_registers.sv
// self-checking testbench of the converter control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
end
module tb_adc_control_registers;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] awaddr_in = 8'h00;
    logic [7:0] araddr_in = 8'h00;
    logic awvalid_in = 1'b0;
    logic wvalid_in = 1'b0;
    logic bready_in = 1'b0;
    logic arvalid_in = 1'b0;
    logic rready_in = 1'b0;
    logic [31:0] wdata_in = 32'h00000000;
    logic [3:0] wstrb_in = 4'hF;
    logic [3:0] pin_pull_high_in = 4'hF;
    logic [3:0] pin_dir_oe_in = 4'hF;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, converter_power_out;
    logic conv_clock_tick_out, sample_phase_out, convert_phase_out, conv_busy_flag_out;
    logic conv_done_flag_out, bandgap_route_out, ground_route_out, reference_internal_out;
    logic reference_pin_route_out;
    logic [1:0] bresp_out, rresp_out;
    logic [31:0] rdata_out;
    logic [11:0] conv_result_in;
    logic [3:0] analog_pin_route_out, pin_pull_high_out, pin_oe_out, pin_alt_enable_out;
    logic [7:0] hi_e, lo_e;
    int bad_count = 0;
    int total_checks = 0;
    int ticks = 0;
    always #2 clk_in = ~clk_in;
    // running count of converter clock ticks, read as a difference by the conversion scenario
    always @(posedge clk_in) ticks <= ticks + int'(conv_clock_tick_out);
    adc_control_registers adc_control_registers_i (.*);
    adc_core_model adc_core_model_i (.clk_in(clk_in), .convert_phase_in(convert_phase_out),
        .analog_pin_route_in(analog_pin_route_out), .bandgap_route_in(bandgap_route_out),
        .ground_route_in(ground_route_out), .result_out(conv_result_in));
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
        int n;
        @(posedge clk_in);
        awaddr_in <= a;
        wdata_in <= {24'h000000, d};
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        bready_in <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_in);
            if (awvalid_in && awready_out) awvalid_in <= 1'b0;
            if (wvalid_in && wready_out) wvalid_in <= 1'b0;
            if (bvalid_out) break;
        end
        bready_in <= 1'b0;
        `CHK("bresp", er, bresp_out)
        if (n == 100) begin
            bad_count++;
            final_report();
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
        int n;
        @(posedge clk_in);
        araddr_in <= a;
        arvalid_in <= 1'b1;
        rready_in <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk_in);
            if (arvalid_in && arready_out) arvalid_in <= 1'b0;
            if (rvalid_out) break;
        end
        rready_in <= 1'b0;
        `CHK("rdata", {24'h000000, d}, rdata_out)
        `CHK("rresp", er, rresp_out)
        if (n == 100) begin
            bad_count++;
            final_report();
        end
    endtask
    task automatic t_bits;
        wr(8'h00, 8'hDF);
        rdc(8'h00, 8'h93);
        wr(8'h00, 8'h00);
        rdc(8'h00, 8'h00);
        wr(8'h1C, 8'h01, 2'h2);
        rdc(8'h18, 8'h00, 2'h2);
        wr(8'h10, 8'h05);
        `CHK("pull", 4'hA, pin_pull_high_out)
        `CHK("oe", 4'hA, pin_oe_out)
        `CHK("alt", 4'hA, pin_alt_enable_out)
    endtask
    task automatic t_route;
        logic [2:0] s;
        wr(8'h10, 8'h1F);
        wr(8'h00, 8'h22);
        for (int i = 0; i < 8; i++) begin
            s = 3'(i);
            // pins and reference pin are released before the source changes
            wr(8'h10, 8'h00);
            wr(8'h04, {s, s[1:0], 3'h0});
            wr(8'h10, {3'h0, s[1:0] != 2'h1, (s == 3'h1) ? 4'h0 : 4'hF});
            `CHK("bandgap", s == 3'h1, bandgap_route_out)
            `CHK("ground", s >= 3'h2 && s <= 3'h4, ground_route_out)
            `CHK("pins", (s == 3'h0 || s >= 3'h5) ? 4'h4 : 4'h0, analog_pin_route_out)
            `CHK("refint", s[1:0] == 2'h1, reference_internal_out)
            `CHK("refpin", s[1:0] != 2'h1, reference_pin_route_out)
        end
    endtask
    task automatic t_conv(input logic [2:0] src, input logic [1:0] ch, input logic fmt, input logic [2:0] dv);
        logic [11:0] r;
        int n;
        int k;
        r = (src == 3'h1) ? 12'h7C3 : (src >= 3'h2 && src <= 3'h4) ? 12'h000 : {4'hA, 4'h1 << ch, 4'h5};
        wr(8'h10, 8'h00);
        wr(8'h04, {src, 2'h0, dv});
        wr(8'h10, (src == 3'h1) ? 8'h00 : {4'h0, 4'h1 << ch});
        wr(8'h00, {3'h5, fmt, 2'h0, ch});
        `CHK("busy", 1'b0, conv_busy_flag_out)
        k = ticks;
        wr(8'h00, {3'h1, fmt, 2'h0, ch});
        `CHK("busy", 1'b1, conv_busy_flag_out)
        `CHK("power", 1'b1, converter_power_out)
        for (n = 1; n < 3000; n++) begin
            @(posedge clk_in);
            if (!conv_busy_flag_out) break;
        end
        if (n == 3000) begin
            bad_count++;
            final_report();
        end
        `CHK("cycles", 16 << dv, n)
        `CHK("ticks", 16, ticks - k)
        `CHK("done", 1'b1, conv_done_flag_out)
        hi_e = fmt ? {4'h0, r[11:8]} : r[11:4];
        lo_e = fmt ? r[7:0] : {r[3:0], 4'h0};
        rdc(8'h08, hi_e);
        rdc(8'h0C, lo_e);
        wr(8'h14, 8'h01);
        `CHK("done", 1'b0, conv_done_flag_out)
    endtask
    task automatic t_abort;
        wr(8'h04, 8'h03);
        wr(8'h10, 8'h01);
        wr(8'h00, 8'hA0);
        wr(8'h00, 8'h20);
        wr(8'h00, 8'h00);
        `CHK("busy", 1'b0, conv_busy_flag_out)
        `CHK("power", 1'b0, converter_power_out)
        repeat (200) @(posedge clk_in);
        rdc(8'h08, hi_e);
        rdc(8'h0C, lo_e);
        `CHK("done", 1'b0, conv_done_flag_out)
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        reset_in <= 1'b0;
        rdc(8'h00, 8'h00);
        rdc(8'h04, 8'h00);
        rdc(8'h08, 8'h00);
        t_bits();
        t_route();
        t_conv(3'h0, 2'h0, 1'b0, 3'h0);
        t_conv(3'h5, 2'h1, 1'b1, 3'h1);
        t_conv(3'h7, 2'h2, 1'b0, 3'h3);
        t_conv(3'h0, 2'h3, 1'b1, 3'h7);
        t_conv(3'h3, 2'h1, 1'b1, 3'h0);
        t_conv(3'h1, 2'h0, 1'b0, 3'h2);
        t_abort();
        final_report();
    end
endmodule
